// [pwr_seq.sv]
// Power mode, wake-up and reset sequencer.
`timescale 1ns/1ps
`include "pwr_seq_regs.svh"
module pwr_seq
   import pwr_seq_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input rst_src_t rst_src,
   input wire logic bod_warn,
   input wire logic bod_irq_en,
   input wire logic osc_running,
   input wire logic flash_init_done,
   input wire logic sleep_req,
   input wire logic pd_req,
   input wire logic dpd_req,
   input wire logic rtc_alarm,
   input wire logic [3:0] ext_irq,
   input wire logic [3:0] ext_wake_en,
   input wire logic other_irq,
   input wire logic vbat_good,
   output pwr_ctl_t pwr_ctl,
   output logic core_rst_n,
   output logic cpu_run,
   output logic flash_access_ok,
   output logic [31:0] fetch_addr,
   output logic brownout_irq,
   output logic brownout_status,
   output logic rtc_alarm_out,
   output logic batt_ram_keep
);
   // ***********************************************
   // Input synchronisers
   // ***********************************************
   logic [3:0] src_m_reg, src_s_reg;
   logic [3:0] ev_m_reg, ev_s_reg;
   logic [1:0] st_m_reg, st_s_reg;
   logic [3:0] ext_m_reg, ext_s_reg;
   // Pins and analog flags pass two flops before use.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         src_m_reg <= 4'hF;
         src_s_reg <= 4'hF;
         ev_m_reg <= 4'h0;
         ev_s_reg <= 4'h0;
         st_m_reg <= 2'h0;
         st_s_reg <= 2'h0;
         ext_m_reg <= 4'h0;
         ext_s_reg <= 4'h0;
      end else if (ce) begin
         src_m_reg <= rst_src;
         src_s_reg <= src_m_reg;
         ev_m_reg <= {bod_warn, rtc_alarm, other_irq, vbat_good};
         ev_s_reg <= ev_m_reg;
         st_m_reg <= {osc_running, flash_init_done};
         st_s_reg <= st_m_reg;
         ext_m_reg <= ext_irq;
         ext_s_reg <= ext_m_reg;
      end
   end
   wire bod_warn_s = ev_s_reg[3];
   wire rtc_alarm_s = ev_s_reg[2];
   wire other_irq_s = ev_s_reg[1];
   wire vbat_good_s = ev_s_reg[0];
   wire osc_ok_s = st_s_reg[1];
   wire flash_ok_s = st_s_reg[0];
   wire pin_rst_s = src_s_reg[3];
   // Any source, including second-stage brownout, requests reset.
   // Power-on after a supply loss restarts through the same path.
   wire any_rst = |src_s_reg;
   wire ext_wake = |(ext_s_reg & ext_wake_en);

   // ***********************************************
   // Sequencer
   // ***********************************************
   pwr_state_t state_reg, state_next;
   logic osc_load, post_load, fl_load, hold_load;
   logic osc_done, post_done, fl_done, hold_done;
   logic flash_ok_reg, flash_ok_next;
   // Next-state selection for modes and wake-up.
   always_comb begin
      state_next = state_reg;
      osc_load = 1'b0;
      post_load = 1'b0;
      fl_load = 1'b0;
      hold_load = 1'b0;
      flash_ok_next = flash_ok_reg && !fl_load;
      case (state_reg)
         st_run: begin
            if (dpd_req) begin
               state_next = st_dpd;
            end else if (pd_req) begin
               state_next = st_pd;
            end else if (sleep_req) begin
               state_next = st_sleep;
            end
         end
         st_sleep: begin
            if (other_irq_s || ext_wake) begin
               state_next = st_resume;
               post_load = 1'b1;
            end
         end
         st_pd: begin
            if (ext_wake || rtc_alarm_s) begin
               state_next = st_osc;
               osc_load = 1'b1;
               fl_load = 1'b1;
            end
         end
         st_osc: begin
            if (osc_done) begin
               state_next = st_resume;
               post_load = 1'b1;
            end
         end
         st_resume: begin
            if (post_done) begin
               state_next = st_run;
            end
         end
         st_dpd: begin
            // Only the alarm or a reset source (pin, watchdog, power-on, brownout) can leave here.
            if (rtc_alarm_s) begin
               state_next = st_rst;
               hold_load = 1'b1;
            end
         end
         st_rst: begin
            if (!pin_rst_s && osc_ok_s && hold_done && flash_ok_s) begin
               state_next = st_run;
            end
         end
         default: begin
            state_next = st_rst;
         end
      endcase
      if (fl_load) begin
         flash_ok_next = 1'b0;
      end else if (fl_done) begin
         flash_ok_next = 1'b1;
      end
      if (any_rst) begin
         state_next = st_rst;
         hold_load = 1'b1;
         flash_ok_next = 1'b1;
      end
   end
   // State and flash gate registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= st_rst;
         flash_ok_reg <= 1'b1;
      end else if (ce) begin
         state_reg <= state_next;
         flash_ok_reg <= flash_ok_next;
      end
   end

   // ***********************************************
   // Timers
   // ***********************************************
   wake_counter u_osc (
      .clk(clk), .arst_n(arst_n), .ce(ce), .load(osc_load),
      .count(12'(`OSC_START_CYC)), .done(osc_done));
   wake_counter u_post (
      .clk(clk), .arst_n(arst_n), .ce(ce), .load(post_load),
      .count(12'(`POST_OSC_CYC)), .done(post_done));
   wake_counter u_flash (
      .clk(clk), .arst_n(arst_n), .ce(ce), .load(fl_load),
      .count(12'(`FLASH_WAKE_CYC)), .done(fl_done));
   wake_counter u_hold (
      .clk(clk), .arst_n(arst_n), .ce(ce), .load(hold_load),
      .count(12'(`RESET_HOLD_CYC)), .done(hold_done));

   // ***********************************************
   // Outputs
   // ***********************************************
   wire low_pwr = (state_reg == st_sleep) || (state_reg == st_pd) ||
      (state_reg == st_osc) || (state_reg == st_dpd);
   wire deep = (state_reg == st_pd) || (state_reg == st_osc) ||
      (state_reg == st_dpd);
   logic [1:0] out_reg;
   // Registered status flags and reset release.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         out_reg <= 2'h0;
      end else if (ce) begin
         out_reg <= {bod_warn_s, (state_next != st_rst)};
      end
   end
   assign core_rst_n = out_reg[0];
   assign brownout_status = out_reg[1];
   assign brownout_irq = out_reg[1] && bod_irq_en;
   assign pwr_ctl.pll_off = low_pwr;
   assign pwr_ctl.div_clear = low_pwr;
   assign pwr_ctl.stop_osc = deep && (state_reg != st_osc);
   assign pwr_ctl.flash_off = deep;
   assign pwr_ctl.core_reg_off = (state_reg == st_dpd);
   assign cpu_run = (state_reg == st_run) && core_rst_n;
   assign flash_access_ok = flash_ok_reg && !deep;
   assign fetch_addr = `BOOT_VECTOR_ADDR;
   assign rtc_alarm_out = rtc_alarm_s && pwr_ctl.core_reg_off;
   assign batt_ram_keep = vbat_good_s;

   // ***********************************************
   // Checks
   // ***********************************************
   a_reset_holds: assert property (@(posedge clk) disable iff (!arst_n)
      ce && any_rst |=> !core_rst_n)
      else $error("reset released while a source is active");
   a_flash_block: assert property (@(posedge clk) disable iff (!arst_n)
      ce && fl_load && !any_rst |=> !flash_access_ok)
      else $error("flash open during wake");
   a_pll_off: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == st_sleep |-> pwr_ctl.pll_off && pwr_ctl.div_clear)
      else $error("pll not off in sleep");
   a_pd_stop: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == st_pd |-> pwr_ctl.stop_osc && pwr_ctl.flash_off)
      else $error("power-down left osc or flash on");
   a_osc_wait: assert property (@(posedge clk) disable iff (!arst_n)
      ce && osc_load && !any_rst |=> state_reg == st_osc)
      else $error("no oscillator wait");
   a_dpd_wake: assert property (@(posedge clk) disable iff (!arst_n)
      state_reg == st_dpd && !rtc_alarm_s && !any_rst && ce
      |=> state_reg == st_dpd)
      else $error("deep power-down left without cause");
   a_bod_irq: assert property (@(posedge clk) disable iff (!arst_n)
      brownout_irq |-> brownout_status)
      else $error("irq without status");
   a_fetch_zero: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(core_rst_n) |-> fetch_addr == 32'h0000_0000)
      else $error("bad reset vector");
endmodule : pwr_seq

// [pwr_seq_regs.svh]
// Constants for the power mode and reset sequencer.
`ifndef PWR_SEQ_REGS_SVH
`define PWR_SEQ_REGS_SVH
`define CLK_FREQ_MHZ 20
`define OSC_START_US 60
`define OSC_START_CYC ((`OSC_START_US * `CLK_FREQ_MHZ))
`define POST_OSC_CYC 4
`define FLASH_WAKE_US 100
`define FLASH_WAKE_CYC ((`FLASH_WAKE_US * `CLK_FREQ_MHZ))
`define RESET_HOLD_CYC 16
`define BOOT_VECTOR_ADDR 32'h0000_0000
`define CNT_W 12
`endif

// [pwr_seq_pkg.sv]
// Types for the power mode and reset sequencer.
package pwr_seq_pkg;
   typedef enum {st_run, st_sleep, st_pd, st_osc, st_resume,
      st_dpd, st_rst} pwr_state_t;
   typedef struct packed {
      logic pin_rst;
      logic wdt_rst;
      logic por_rst;
      logic bod_rst;
   } rst_src_t;
   typedef struct packed {
      logic stop_osc;
      logic flash_off;
      logic pll_off;
      logic div_clear;
      logic core_reg_off;
   } pwr_ctl_t;
endpackage : pwr_seq_pkg

// [wake_counter.sv]
// Loadable down counter that signals expiry.
`timescale 1ns/1ps
module wake_counter
   import pwr_seq_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic load,
   input wire logic [11:0] count,
   output logic done
);
   logic [11:0] cnt_reg;
   logic run_reg;
   // Counts down after a load and flags zero.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 12'h000;
         run_reg <= 1'b0;
      end else if (ce) begin
         if (load) begin
            cnt_reg <= count;
            run_reg <= 1'b1;
         end else if (cnt_reg != 12'h000) begin
            cnt_reg <= cnt_reg - 12'h001;
         end
      end
   end
   assign done = run_reg && (cnt_reg == 12'h000) && !load;
endmodule : wake_counter

// [osc_flash_model.sv]
// Model of the oscillator and flash controller facing the sequencer.
`timescale 1ns/1ps
module osc_flash_model #(
   parameter int DELAY = 3
) (
   input wire logic clk,
   input wire logic stop,
   output logic osc_running,
   output logic flash_init_done
);
   int cnt = 0;
   // A stop request kills both ready levels at once; they come back slowly.
   always @(posedge clk) begin
      if (stop === 1'b1) begin
         cnt <= 0;
      end else if (cnt < 4 * DELAY) begin
         cnt <= cnt + 1;
      end
   end
   // Flash finishes its own start-up after the oscillator is up.
   assign osc_running = (cnt >= DELAY);
   assign flash_init_done = (cnt >= 2 * DELAY);
endmodule : osc_flash_model

// [power_mode_reset_sequencer_tb.sv]
// Self-checking testbench of the power mode and reset sequencer.
`timescale 1ns/1ps
module power_mode_reset_sequencer_tb
   import pwr_seq_pkg::*;
;
   // ****************************************************************
   // Signals, clock and partner.
   // ****************************************************************
   logic clk = 1'b0, arst_n = 1'b0, bod_warn = 1'b0, bod_irq_en = 1'b0;
   logic pd_req = 1'b0, dpd_req = 1'b0, rtc_alarm = 1'b0;
   logic sleep_req = 1'b0, other_irq = 1'b0, vbat_good = 1'b1;
   logic alarm_out, batt_keep;
   logic [3:0] ext_irq = 4'h0, ext_wake_en = 4'h0;
   rst_src_t rst_src = 4'h0;
   pwr_ctl_t pwr_ctl;
   logic core_rst_n, cpu_run, flash_ok, osc_ok, flash_done, brn_irq;
   logic brn_stat;
   logic [31:0] fetch_addr;
   int error_cnt = 0, comparisons = 0;
   initial begin
      forever #25 clk = ~clk;
   end
   osc_flash_model #(.DELAY(20)) model (.clk(clk),
      .stop(pwr_ctl.stop_osc | pwr_ctl.core_reg_off),
      .osc_running(osc_ok), .flash_init_done(flash_done));
   pwr_seq DUT (.clk(clk), .arst_n(arst_n), .ce(1'b1), .rst_src(rst_src),
      .bod_warn(bod_warn), .bod_irq_en(bod_irq_en), .osc_running(osc_ok),
      .flash_init_done(flash_done), .sleep_req(sleep_req), .pd_req(pd_req),
      .dpd_req(dpd_req), .rtc_alarm(rtc_alarm), .ext_irq(ext_irq),
      .ext_wake_en(ext_wake_en), .other_irq(other_irq),
      .vbat_good(vbat_good),
      .pwr_ctl(pwr_ctl), .core_rst_n(core_rst_n), .cpu_run(cpu_run),
      .flash_access_ok(flash_ok), .fetch_addr(fetch_addr),
      .brownout_irq(brn_irq), .brownout_status(brn_stat),
      .rtc_alarm_out(alarm_out), .batt_ram_keep(batt_keep));
   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   // Compares one value and reports a mismatch at once.
   task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Counts falling edges until the chosen output is high, up to a limit.
   task automatic wait_hi(input int sel, input int lim, output int n);
      logic [2:0] mon;
      n = 0;
      mon = {flash_ok, cpu_run, core_rst_n};
      while (mon[sel] !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
         mon = {flash_ok, cpu_run, core_rst_n};
      end
   endtask : wait_hi
   task automatic finish_test;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   // Reset stays in while the pin is held, then lets go from address zero.
   task automatic reset_release;
      int n;
      @(posedge clk) rst_src.pin_rst <= 1'b1;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      repeat (60) @(negedge clk);
      chk("core_rst_n with pin held", 0, core_rst_n);
      @(posedge clk) rst_src.pin_rst <= 1'b0;
      wait_hi(0, 200, n);
      chk("reset released", 1, n < 200 && n >= 16);
      chk("fetch_addr", 32'h0000_0000, fetch_addr);
   endtask : reset_release
   // Each of the four sources alone pulls internal reset.
   task automatic reset_sources;
      int n;
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) rst_src <= rst_src_t'(4'h1 << i);
         repeat (4) @(negedge clk);
         chk("core_rst_n under source", 0, core_rst_n);
         @(posedge clk) rst_src <= 4'h0;
         wait_hi(0, 200, n);
         chk("release after source", 1, core_rst_n);
      end
   endtask : reset_sources
   // Power-down, wake by an enabled external interrupt, timed resume.
   task automatic power_down;
      int n = 0, t_run = 0, t_fl = 0;
      @(posedge clk) ext_wake_en <= 4'h2;
      pd_req <= 1'b1;
      @(posedge clk) pd_req <= 1'b0;
      repeat (30) @(negedge clk);
      chk("pd controls", 5'h1E, pwr_ctl);
      chk("cpu halted", 0, cpu_run);
      @(posedge clk) ext_irq <= 4'h1;
      repeat (20) @(negedge clk);
      chk("masked wake ignored", 0, cpu_run);
      @(posedge clk) ext_irq <= 4'h2;
      while ((t_run == 0 || t_fl == 0) && n < 3000) begin
         @(negedge clk);
         n++;
         if (cpu_run === 1'b1 && t_run == 0) t_run = n;
         if (flash_ok === 1'b1 && t_fl == 0) t_fl = n;
      end
      chk("resume delay", 1, t_run >= 1204 && t_run <= 1212);
      chk("flash gate", 1, t_fl >= 2000 && t_fl <= 2008);
      @(posedge clk) ext_irq <= 4'h0;
   endtask : power_down
   // Deep power-down ignores interrupts and wakes through a full reset.
   task automatic deep_power_down;
      int n;
      @(posedge clk) dpd_req <= 1'b1;
      @(posedge clk) dpd_req <= 1'b0;
      repeat (10) @(negedge clk);
      chk("regulator off", 1, pwr_ctl.core_reg_off);
      @(posedge clk) ext_irq <= 4'h2;
      repeat (50) @(negedge clk);
      chk("interrupt no wake", 0, cpu_run);
      @(posedge clk) ext_irq <= 4'h0;
      rtc_alarm <= 1'b1;
      repeat (3) @(negedge clk);
      chk("alarm out powered off", 1, alarm_out);
      @(negedge clk);
      chk("alarm out powered on", 0, alarm_out);
      chk("alarm wake", 0, cpu_run);
      wait_hi(1, 3000, n);
      chk("restart after alarm", 1, cpu_run);
      @(posedge clk) rtc_alarm <= 1'b0;
   endtask : deep_power_down
   // First brownout stage shows as status and a maskable interrupt.
   task automatic brownout;
      @(posedge clk) bod_warn <= 1'b1;
      repeat (4) @(negedge clk);
      chk("brownout status", 1, brn_stat);
      chk("masked irq", 0, brn_irq);
      @(posedge clk) bod_irq_en <= 1'b1;
      repeat (2) @(negedge clk);
      chk("brownout irq", 1, brn_irq);
      @(posedge clk) bod_warn <= 1'b0;
      chk("battery ram kept", 1, batt_keep);
      @(posedge clk) vbat_good <= 1'b0;
      repeat (3) @(negedge clk);
      chk("battery ram dropped", 0, batt_keep);
      @(posedge clk) vbat_good <= 1'b1;
   endtask : brownout
   // Sleep turns the PLL off, keeps flash on and wakes on an interrupt.
   task automatic sleep_mode;
      int n;
      @(posedge clk) sleep_req <= 1'b1;
      @(posedge clk) sleep_req <= 1'b0;
      repeat (4) @(negedge clk);
      chk("sleep controls", 5'h06, pwr_ctl);
      chk("sleep flash on", 1, flash_ok);
      chk("sleep halted", 0, cpu_run);
      @(posedge clk) other_irq <= 1'b1;
      wait_hi(1, 20, n);
      chk("sleep wake cycles", 9, n);
      // Software owns the PLL again once the core runs.
      chk("pll free after wake", 0, pwr_ctl.pll_off);
      @(posedge clk) other_irq <= 1'b0;
   endtask : sleep_mode
   initial begin
      #(50 * 20000);
      error_cnt++;
      finish_test();
   end
   initial begin
      reset_release();
      reset_sources();
      power_down();
      deep_power_down();
      brownout();
      sleep_mode();
      finish_test();
   end
endmodule : power_mode_reset_sequencer_tb
